// ==== design/spp_device.sv ====
`timescale 1ns/10ps
// Purpose: Device end of the serial control port
// Assumes: Link pins are asynchronous; sampled through two flops
// Notes:   Register file is flip-flops; core clock select steers a mux
// Functional notes
// - Read data shifts out with host clock
// - Data-out low flags enabled pending interrupt
// - Interrupt shown only while selected
// - Input data shifts in on clock
// - Select active low; ignore traffic when high
// - Frames delimited by chip select
// - Deselect edge resets serial logic
// - Host alone supplies serial clock
// - External select moves core clock to pin
// - Core runs from whatever clock is applied
// - Pin zero otherwise register-driven I/O
module spp_device
   import spp_pkg::*;
(
   input  wire logic                  i_mclk,          // System clock
   input  wire logic                  i_reset,         // Sync reset, high
   spp_if.dev                         link,            // Serial link
   input  wire logic [SPP_IRQ_N-1:0]  i_irq_events,    // Event pulses
   input  wire logic                  i_general_io_pin_zero_in,      // Pin zero input
   input  wire logic                  i_int_clk,       // Internal osc
   output logic                       o_general_io_pin_zero_out,     // Pin zero out
   output logic                       o_general_io_pin_zero_oe,      // Pin zero enable
   output logic                       o_core_clk_sel,  // 1: pin clock
   output logic                       o_general_io_pin_zero_level,   // Synced pin level
   output logic                       o_core_clk,      // Chosen core clk
   output logic                       o_wr_strobe,     // Register written
   output logic [SPP_ADDR_W-1:0]      o_wr_addr        // Written address
);
   import spp_pkg::*;

   typedef enum {SPP_CMD, SPP_DATA, SPP_DONE} spp_phase_t;

   typedef struct packed {
      logic [1:0]                       sclk_s;
      logic [1:0]                       cs_s;
      logic [1:0]                       sdi_s;
      logic [1:0]                       g0_s;
      logic [1:0]                       ck_s;
      logic                             sclk_d;
      logic                             cs_d;
      spp_phase_t                       phase;
      logic [SPP_CNT_W-1:0]             bit_cnt;
      logic [SPP_BYTE_W-1:0]            shreg;
      logic [SPP_BYTE_W-1:0]            cmd;
      logic [SPP_BYTE_W-1:0]            txreg;
      logic                             dout;
      logic                             dout_oe;
      logic [SPP_IRQ_N-1:0]             irq_pend;
      logic                             g0_out;
      logic                             g0_oe;
      logic                             clk_sel;
      logic                             g0_lvl;
      logic                             core_clk;
      logic                             wr_stb;
      logic [SPP_ADDR_W-1:0]            wr_addr;
   } spp_dev_st_t;

   spp_dev_st_t                      st_r;
   spp_dev_st_t                      st_nxt;
   logic [SPP_BYTE_W-1:0]            regs_r [SPP_REG_N];
   logic                             reg_we;
   logic [SPP_ADDR_W-1:0]            reg_wa;
   logic [SPP_BYTE_W-1:0]            reg_wd;

   function automatic logic [SPP_BYTE_W-1:0] rd_val(
      input logic [SPP_ADDR_W-1:0] a);
      logic [SPP_BYTE_W-1:0] v;
      v = regs_r[a];
      if (a == SPP_ADDR_CTRL) begin
         v[SPP_CTRL_G0OUT] = st_r.g0_lvl;
      end
      return v;
   endfunction

   always_comb begin
      logic sclk_rise;
      logic sclk_fall;
      logic cs_act;
      logic cs_rise;
      logic [SPP_BYTE_W-1:0] nsh;
      logic [SPP_IRQ_N-1:0] irq_clr;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      cs_act    = 1'b0;
      cs_rise   = 1'b0;
      nsh       = SPP_BYTE_ZERO;
      irq_clr   = '0;
      st_nxt    = st_r;
      reg_we    = 1'b0;
      reg_wa    = '0;
      reg_wd    = SPP_BYTE_ZERO;
      st_nxt.sclk_s = {st_r.sclk_s[0], link.sclk};
      st_nxt.cs_s   = {st_r.cs_s[0], link.chip_select_n};
      st_nxt.sdi_s  = {st_r.sdi_s[0], link.sdi};
      st_nxt.g0_s   = {st_r.g0_s[0], i_general_io_pin_zero_in};
      st_nxt.ck_s   = {st_r.ck_s[0], i_int_clk};
      st_nxt.sclk_d = st_r.sclk_s[1];
      st_nxt.cs_d   = st_r.cs_s[1];
      st_nxt.wr_stb = 1'b0;
      sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_d;
      sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_d;
      cs_act    = ~st_r.cs_s[1];
      cs_rise   = st_r.cs_s[1] & ~st_r.cs_d;
      st_nxt.g0_lvl = st_r.g0_s[1];
      nsh = {st_r.shreg[SPP_BYTE_W-2:0], st_r.sdi_s[1]};
      if (cs_rise | ~cs_act) begin
         // Partial frames are dropped; next select starts afresh
         st_nxt.phase   = SPP_CMD;
         st_nxt.bit_cnt = SPP_BIT_ZERO;
         st_nxt.shreg   = SPP_BYTE_ZERO;
         st_nxt.txreg   = SPP_BYTE_ZERO;
      end else if (sclk_rise && st_r.phase != SPP_DONE) begin
         st_nxt.shreg   = nsh;
         st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
         if (st_r.bit_cnt[2:0] == SPP_BIT_LAST[2:0]) begin
            st_nxt.bit_cnt = SPP_BIT_ZERO;
            if (st_r.phase == SPP_CMD) begin
               st_nxt.cmd   = nsh;
               st_nxt.phase = SPP_DATA;
               st_nxt.txreg = rd_val(nsh[SPP_ADDR_W-1:0]);
            end else begin
               st_nxt.phase = SPP_DONE;
               if (!st_r.cmd[SPP_RD_BIT]) begin
                  reg_we = 1'b1;
                  reg_wa = st_r.cmd[SPP_ADDR_W-1:0];
                  reg_wd = nsh;
                  st_nxt.wr_stb  = 1'b1;
                  st_nxt.wr_addr = reg_wa;
                  if (reg_wa == SPP_ADDR_IRQEN) begin
                     irq_clr = ~nsh;
                  end
               end else if (st_r.cmd[SPP_ADDR_W-1:0] == SPP_ADDR_IRQEN) begin
                  irq_clr = '1;                           // read clears
               end
            end
         end
      end else if (sclk_fall && st_r.phase == SPP_DATA &&
                   st_r.cmd[SPP_RD_BIT]) begin
         // Shift on falling edge so host samples a stable bit
         st_nxt.dout  = st_r.txreg[SPP_BYTE_W-1];
         st_nxt.txreg = {st_r.txreg[SPP_BYTE_W-2:0], 1'b0};
      end
      // New events win over a clear in the same cycle
      st_nxt.irq_pend = (st_r.irq_pend & ~irq_clr) | i_irq_events;
      st_nxt.dout_oe  = cs_act;
      if (!(st_r.phase == SPP_DATA && st_r.cmd[SPP_RD_BIT])) begin
         st_nxt.dout = ~|(st_r.irq_pend & regs_r[SPP_ADDR_IRQEN]);
      end
      if (!cs_act) begin
         st_nxt.dout = 1'b1;
      end
      st_nxt.clk_sel = regs_r[SPP_ADDR_CTRL][SPP_CTRL_EXTERNAL_CLOCK_SELECT];
      st_nxt.g0_oe   = ~st_nxt.clk_sel &
                       regs_r[SPP_ADDR_CTRL][SPP_CTRL_G0DIR];
      st_nxt.g0_out  = regs_r[SPP_ADDR_CTRL][SPP_CTRL_G0OUT];
      // Core clock is a resampled copy; rate scales with source
      st_nxt.core_clk = st_r.clk_sel ? st_r.g0_s[1]
                                     : st_r.ck_s[1];
      if (i_reset) begin
         st_nxt = '0;
         st_nxt.cs_s   = 2'b11;
         st_nxt.cs_d   = 1'b1;
         st_nxt.dout   = 1'b1;
         st_nxt.phase  = SPP_CMD;
      end
   end

   always_ff @(posedge i_mclk) begin
      st_r <= st_nxt;
   end

   generate
      for (genvar g = 0; g < SPP_REG_N; g++) begin : g_reg
         always_ff @(posedge i_mclk) begin
            if (i_reset) begin
               regs_r[g] <= SPP_BYTE_ZERO;
            end else if (reg_we && reg_wa == SPP_ADDR_W'(g)) begin
               regs_r[g] <= reg_wd;
            end
         end
      end
   endgenerate

   assign link.data_out_irq_n    = st_r.dout;
   assign link.data_out_irq_n_oe = st_r.dout_oe;
   assign o_general_io_pin_zero_out    = st_r.g0_out;
   assign o_general_io_pin_zero_oe     = st_r.g0_oe;
   assign o_core_clk_sel = st_r.clk_sel;
   assign o_general_io_pin_zero_level  = st_r.g0_lvl;
   assign o_core_clk     = st_r.core_clk;
   assign o_wr_strobe    = st_r.wr_stb;
   assign o_wr_addr      = st_r.wr_addr;
endmodule

// ==== design/spp_pkg.sv ====
// Purpose: Shared constants for the serial control port pair
// Assumes: 8-bit command byte then 8-bit data byte, MSB first
// Notes:   Command bit 7 high means read; bits 6:0 address a register
package spp_pkg;
   localparam int          SPP_BYTE_W      = 8;
   localparam int          SPP_ADDR_W      = 7;
   localparam int          SPP_REG_N       = 128;
   localparam int          SPP_CNT_W       = 4;
   localparam int          SPP_RD_BIT      = 7;
   localparam logic [3:0]  SPP_BIT_LAST    = 4'h7;
   localparam logic [3:0]  SPP_BIT_ZERO    = 4'h0;
   localparam logic [7:0]  SPP_BYTE_ZERO   = 8'h00;
   // Dedicated register addresses for the pin and clock controls and the interrupt enable
   localparam logic [6:0]  SPP_ADDR_CTRL   = 7'h01;
   localparam logic [6:0]  SPP_ADDR_IRQEN  = 7'h02;
   localparam int          SPP_CTRL_EXTERNAL_CLOCK_SELECT = 0;
   localparam int          SPP_CTRL_G0DIR  = 1;
   localparam int          SPP_CTRL_G0OUT  = 2;
   localparam int          SPP_IRQ_N       = 8;
   // Host clock divider: half period in system clocks
   localparam int          SPP_SYS_NS      = 40;
   localparam int          SPP_SCLK_NS     = 320;
   localparam int          SPP_HALF_CYC    = SPP_SCLK_NS / SPP_SYS_NS / 2;
   localparam logic [3:0]  SPP_HALF_LAST   = 4'(SPP_HALF_CYC - 1);
   // Nominal core clock in kHz, for reference only
   localparam int          SPP_CORE_KHZ    = 2458;
endpackage

// ==== design/spp_if.sv ====
`timescale 1ns/10ps
// Purpose: Four-wire serial link between host and device
// Assumes: Data-out enable travels alongside; the host reads data-out without it
// Notes:   No clocking block
interface spp_if;
   logic sclk;
   logic chip_select_n;
   logic sdi;
   logic data_out_irq_n;
   logic data_out_irq_n_oe;
   modport dev  (input sclk, chip_select_n, sdi,
                 output data_out_irq_n, data_out_irq_n_oe);
   modport host (output sclk, chip_select_n, sdi,
                 input data_out_irq_n, data_out_irq_n_oe);
endinterface

// ==== design/spp_host.sv ====
`timescale 1ns/10ps
// Purpose: Host end of the serial control port; makes the serial clock
// Assumes: One command byte and one data byte per frame
// Notes:   Drives data and samples data-out on each falling clock edge
module spp_host
   import spp_pkg::*;
(
   input  wire logic                  i_mclk,      // System clock
   input  wire logic                  i_reset,     // Sync reset, high
   spp_if.host                        link,        // Serial link
   input  wire logic                  i_start,     // Start a frame
   input  wire logic                  i_read,      // 1: read, 0: write
   input  wire logic [SPP_ADDR_W-1:0] i_addr,      // Register address
   input  wire logic [SPP_BYTE_W-1:0] i_wdata,     // Write data
   output logic                       o_busy,      // Frame running
   output logic                       o_done,      // Frame finished
   output logic [SPP_BYTE_W-1:0]      o_rdata,     // Read data
   output logic                       o_irq_n      // Sampled irq level
);
   import spp_pkg::*;

   typedef enum {SPP_IDLE, SPP_SEL, SPP_SHIFT, SPP_END} spp_hstate_t;

   typedef struct packed {
      spp_hstate_t                   state;
      logic [3:0]                    div;
      logic [SPP_CNT_W:0]            bits;
      logic [2*SPP_BYTE_W-1:0]       tx;
      logic [SPP_BYTE_W-1:0]         rx;
      logic                          sclk;
      logic                          csn;
      logic                          sdo;
      logic                          busy;
      logic                          done;
      logic [1:0]                    din_s;
      logic                          irq_n;
   } spp_host_st_t;

   spp_host_st_t st_r;
   spp_host_st_t st_nxt;

   always_comb begin
      logic tick;
      tick = 1'b0;
      st_nxt = st_r;
      st_nxt.done  = 1'b0;
      st_nxt.din_s = {st_r.din_s[0], link.data_out_irq_n};
      tick = (st_r.div == SPP_HALF_LAST);
      st_nxt.div = tick ? 4'h0 : st_r.div + 4'h1;
      case (st_r.state)
         SPP_IDLE: begin
            st_nxt.div = 4'h0;
            st_nxt.irq_n = st_r.din_s[1];
            if (i_start) begin
               st_nxt.tx    = {i_read, i_addr, i_wdata};
               st_nxt.csn   = 1'b0;
               st_nxt.busy  = 1'b1;
               st_nxt.bits  = '0;
               st_nxt.sdo   = i_read;
               st_nxt.state = SPP_SEL;
            end
         end
         SPP_SEL: begin
            if (tick) begin
               st_nxt.state = SPP_SHIFT;
            end
         end
         SPP_SHIFT: begin
            if (tick) begin
               st_nxt.sclk = ~st_r.sclk;
               if (!st_r.sclk) begin
                  st_nxt.bits = st_r.bits + 5'h01;
               end else begin
                  // Data-out lags five clocks through both synchronisers,
                  // so the bit is only settled here, a half period late
                  st_nxt.rx  = {st_r.rx[SPP_BYTE_W-2:0], st_r.din_s[1]};
                  st_nxt.tx  = {st_r.tx[2*SPP_BYTE_W-2:0], 1'b0};
                  st_nxt.sdo = st_r.tx[2*SPP_BYTE_W-2];
                  if (st_r.bits == 5'(2 * SPP_BYTE_W)) begin
                     st_nxt.state = SPP_END;
                  end
               end
            end
         end
         SPP_END: begin
            if (tick) begin
               st_nxt.csn   = 1'b1;
               st_nxt.busy  = 1'b0;
               st_nxt.done  = 1'b1;
               st_nxt.state = SPP_IDLE;
            end
         end
         default: begin
            st_nxt.state = SPP_IDLE;
         end
      endcase
      if (i_reset) begin
         st_nxt = '0;
         st_nxt.csn   = 1'b1;
         st_nxt.irq_n = 1'b1;
         st_nxt.din_s = 2'b11;
         st_nxt.state = SPP_IDLE;
      end
   end

   always_ff @(posedge i_mclk) begin
      st_r <= st_nxt;
   end

   assign link.sclk          = st_r.sclk;
   assign link.chip_select_n = st_r.csn;
   assign link.sdi           = st_r.sdo;
   assign o_busy  = st_r.busy;
   assign o_done  = st_r.done;
   assign o_rdata = st_r.rx;
   assign o_irq_n = st_r.irq_n;
endmodule

// ==== bench/spp_checker.sv ====
// Purpose: Protocol checks on the serial link wires
// Assumes: Host divider half period of four system clocks
// Notes:   Reset input covers either end being held in reset
`timescale 1ns/10ps
module spp_checker (
   input  wire logic i_mclk,            // System clock
   input  wire logic i_reset,           // Either end in reset
   input  wire logic sclk,              // Serial clock
   input  wire logic chip_select_n,     // Select, active low
   input  wire logic sdi,               // Host data
   input  wire logic data_out_irq_n,    // Device data or irq
   input  wire logic data_out_irq_n_oe  // Device drive enable
);
   logic [4:0] rise_r;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   // Rises seen in the current frame; cleared while deselected
   always_ff @(posedge i_mclk) begin
      if (i_reset || chip_select_n) begin
         rise_r <= 5'h00;
      end else if ($rose(sclk)) begin
         rise_r <= rise_r + 5'h01;
      end
   end

   a_oe_released: assert property (
      chip_select_n [*4] |-> !data_out_irq_n_oe)
      else $error("data out driven while deselected");
   a_oe_driven: assert property (
      !chip_select_n [*4] |-> data_out_irq_n_oe)
      else $error("data out not driven while selected");
   a_clk_parked: assert property (
      chip_select_n [*4] |-> !sclk)
      else $error("serial clock runs outside a frame");
   a_clk_half: assert property (
      $rose(sclk) |-> sclk [*4])
      else $error("serial clock high phase too short");
   a_frame_lead: assert property (
      $fell(chip_select_n) |-> !sclk [*4])
      else $error("serial clock starts too soon after select");
   a_sdi_hold: assert property (
      $changed(sdi) && !chip_select_n && !$fell(chip_select_n) |-> !sclk)
      else $error("host data changed while clock high");
   a_cs_gap: assert property (
      $rose(chip_select_n) |-> chip_select_n [*4])
      else $error("deselect gap too short");
   a_bit_count: assert property (
      $rose(chip_select_n) |-> rise_r == 5'h10)
      else $error("frame did not hold sixteen clock rises");
endmodule

// ==== bench/serial_port_pin_behaviour_bench.sv ====
// Purpose: End-to-end bench for the host and device serial ends
// Assumes: Host end makes the serial clock; pin zero resolved here
// Notes:   Separate resets let a frame be cut short from the host side
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serial_port_pin_behaviour_bench;
   import spp_pkg::*;
   logic                  i_mclk, rst_h, rst_d, start, rd, done, irq_v, got;
   logic                  int_clk, pin_drv, g_out, g_oe, g_lvl, clk_sel;
   logic                  wr_stb, gpio_pin, core_clk;
   logic [SPP_ADDR_W-1:0] addr, wr_addr;
   logic [SPP_BYTE_W-1:0] wdata, rdata;
   logic [SPP_IRQ_N-1:0]  irq;
   logic [6:0]            tab_a [3] = '{7'h00, 7'h05, 7'h7F};
   logic [7:0]            tab_d [3] = '{8'h81, 8'hA5, 8'h5A};
   int                    n_fail = 0, comparisons = 0, cycles = 0;
   int                    n_wr = 0, n0;

   spp_if spp_if_i ();
   // Pin zero: device drives when enabled, otherwise the bench source
   assign gpio_pin = g_oe ? g_out : pin_drv;

   spp_device spp_device_i (.i_mclk(i_mclk), .i_reset(rst_d),
      .link(spp_if_i.dev), .i_irq_events(irq), .i_general_io_pin_zero_in(gpio_pin),
      .i_int_clk(int_clk), .o_general_io_pin_zero_out(g_out), .o_general_io_pin_zero_oe(g_oe),
      .o_core_clk_sel(clk_sel), .o_general_io_pin_zero_level(g_lvl), .o_core_clk(core_clk),
      .o_wr_strobe(wr_stb), .o_wr_addr(wr_addr));
   spp_host spp_host_i (.i_mclk(i_mclk), .i_reset(rst_h),
      .link(spp_if_i.host), .i_start(start), .i_read(rd), .i_addr(addr),
      .i_wdata(wdata), .o_busy(), .o_done(done), .o_rdata(rdata),
      .o_irq_n());
   spp_checker spp_checker_i (.i_mclk(i_mclk), .i_reset(rst_h | rst_d),
      .sclk(spp_if_i.sclk), .chip_select_n(spp_if_i.chip_select_n),
      .sdi(spp_if_i.sdi), .data_out_irq_n(spp_if_i.data_out_irq_n),
      .data_out_irq_n_oe(spp_if_i.data_out_irq_n_oe));

   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk) begin
      int_clk <= ~int_clk;
      if (wr_stb === 1'b1) n_wr++;
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One whole frame; notes the irq level seen once the device drives
   task automatic xfer(input logic r, input logic [6:0] a,
                       input logic [7:0] d);
      int n;
      n = 0;
      got = 1'b0;
      @(posedge i_mclk);
      start <= 1'b1;
      rd    <= r;
      addr  <= a;
      wdata <= d;
      @(posedge i_mclk);
      start <= 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge i_mclk);
         n++;
         if (!got && spp_if_i.data_out_irq_n_oe === 1'b1) begin
            irq_v = spp_if_i.data_out_irq_n;
            got   = 1'b1;
         end
      end
      if (n >= 400) n_fail++;
      repeat (6) @(posedge i_mclk);
   endtask

   task automatic pulse(input logic [7:0] e);
      @(posedge i_mclk);
      irq <= e;
      @(posedge i_mclk);
      irq <= 8'h00;
      repeat (4) @(posedge i_mclk);
   endtask

   initial begin
      {rst_h, rst_d, start, rd, int_clk, pin_drv} = 6'h30;
      addr  = 7'h00;
      wdata = 8'h00;
      irq   = 8'h00;
      repeat (6) @(posedge i_mclk);
      rst_h <= 1'b0;
      rst_d <= 1'b0;
      foreach (tab_a[k]) xfer(1'b0, tab_a[k], tab_d[k]);
      `CHK(wr_addr, 7'h7F)
      foreach (tab_a[k]) begin
         xfer(1'b1, tab_a[k], 8'h00);
         `CHK(rdata, tab_d[k])
      end
      $display("test registers done");
      // Cut a write inside its data byte (twelve rises); nothing may commit
      n0 = n_wr;
      @(posedge i_mclk);
      start <= 1'b1;
      rd    <= 1'b0;
      addr  <= 7'h05;
      wdata <= 8'h3C;
      @(posedge i_mclk);
      start <= 1'b0;
      repeat (100) @(posedge i_mclk);
      rst_h <= 1'b1;
      // Held long enough that the select rise is seen under reset
      repeat (3) @(posedge i_mclk);
      rst_h <= 1'b0;
      repeat (8) @(posedge i_mclk);
      `CHK(n_wr, n0)
      xfer(1'b1, 7'h05, 8'h00);
      `CHK(rdata, 8'hA5)
      $display("test abort done");
      xfer(1'b0, SPP_ADDR_CTRL, 8'h06);
      `CHK({g_oe, g_out, g_lvl}, 3'h7)
      xfer(1'b1, SPP_ADDR_CTRL, 8'h00);
      `CHK(rdata, 8'h06)
      xfer(1'b0, SPP_ADDR_CTRL, 8'h01);
      `CHK({clk_sel, g_oe}, 2'h2)
      pin_drv <= 1'b1;
      repeat (8) @(posedge i_mclk);
      `CHK(core_clk, 1'b1)
      pin_drv <= 1'b0;
      repeat (8) @(posedge i_mclk);
      `CHK(core_clk, 1'b0)
      $display("test pin zero done");
      xfer(1'b0, SPP_ADDR_IRQEN, 8'h01);
      pulse(8'h01);
      `CHK(spp_if_i.data_out_irq_n_oe, 1'b0)
      xfer(1'b0, 7'h03, 8'h00);
      `CHK(irq_v, 1'b0)
      xfer(1'b1, SPP_ADDR_IRQEN, 8'h00);
      `CHK(rdata, 8'h01)
      pulse(8'h02);
      xfer(1'b0, 7'h03, 8'h00);
      `CHK(irq_v, 1'b1)
      $display("test interrupt done");
      final_report();
   end
endmodule
